/* src/irq_and_charger_status_regs.sv */
// Operation
// - Button change raises the interrupt only while mask bit 6 is clear.
// - Mains change raises the interrupt only while mask bit 5 is clear.
// - Bus power change raises the interrupt only while mask bit 4 is clear.
// - Bit 1 flag sets when mains power is applied or removed.
// - Bit 0 flag sets when bus power is applied or removed.
// - Bit 7 is writable and resets to one; bit 3 reads zero.
// - Flags only mark changes; present levels read from a separate register.
// - Status bit 7 shows thermal regulation reducing charge current.
// - Status bit 6 shows the dynamic power-path loop is active.
// - Status bit 5 shows charging suspended for battery temperature.
// - Status bit 4 shows termination current crossed and charging stopped.
// - Status bit 3 shows the charger is actively charging.
// - Status bit 2 shows some charge timer expired.
// - Status bit 1 shows the precharge timer expired.
// - Status bit 0 shows missing sensor or temperature out of range.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module irq_and_charger_status_regs (
    input wire logic pclk, // APB clock, 200 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB write byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire irq_status_pkg::source_level_s sources, // Present source levels
    input wire irq_status_pkg::charger_state_s charger, // Charger conditions
    output logic irq // Level interrupt, active high
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic setup;
    logic rd_strobe;
    logic wr_strobe;
    logic hit_irq;
    logic hit_chg;
    logic hit_lvl;
    logic mapped;
    logic read_clears;

    assign setup = psel && !penable;
    assign hit_irq = (paddr == irq_status_pkg::addr_irq_flag_mask);
    assign hit_chg = (paddr == irq_status_pkg::addr_charger_status);
    assign hit_lvl = (paddr == irq_status_pkg::addr_source_level);
    assign mapped = hit_irq || hit_chg || hit_lvl;
    // The slave answers in the first access cycle, so each transfer has
    // exactly one edge with psel, penable and pready all high.
    assign rd_strobe = psel && penable && pready && !pwrite;
    assign wr_strobe = psel && penable && pready && pwrite;
    assign read_clears = rd_strobe && hit_irq;

    // ------------------------------------------------------------------
    // Source sampling and change detection
    // ------------------------------------------------------------------
    irq_status_pkg::source_level_s level_q;
    logic [2:0] change;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= '0;
        end else begin
            level_q <= sources;
        end
    end

    // A source that is already high when reset lifts is a real change.
    assign change[irq_status_pkg::button_flag_bit] =
        sources.push_button_input ^ level_q.push_button_input;
    assign change[irq_status_pkg::mains_flag_bit] =
        sources.mains_present ^ level_q.mains_present;
    assign change[irq_status_pkg::bus_power_flag_bit] =
        sources.bus_power_present ^ level_q.bus_power_present;

    // ------------------------------------------------------------------
    // Change flags, masks and reserved bit
    // ------------------------------------------------------------------
    logic [2:0] flag;
    logic [2:0] mask;
    logic reserved_rw;
    logic [2:0] next_flag;
    logic [2:0] reported;

    // Holds the flags handed out at the read setup edge, so that a flag set
    // after that edge is not cleared before software has seen it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reported <= irq_status_pkg::flag_reset;
        end else if (setup && !pwrite && hit_irq) begin
            reported <= flag;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            // Set wins over the clearing read.
            assign next_flag[gi] = change[gi] ||
                (flag[gi] && !(read_clears && reported[gi]));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= irq_status_pkg::flag_reset;
        end else begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= irq_status_pkg::mask_reset;
            reserved_rw <= irq_status_pkg::reserved_rw_reset;
        end else if (wr_strobe && hit_irq && pstrb[0]) begin
            mask[2] <= pwdata[irq_status_pkg::button_mask_bit];
            mask[1] <= pwdata[irq_status_pkg::mains_mask_bit];
            mask[0] <= pwdata[irq_status_pkg::bus_power_mask_bit];
            reserved_rw <= pwdata[irq_status_pkg::reserved_rw_bit];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // Mask bit order matches flag order: button, mains, bus power.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flag & ~mask);
        end
    end

    // ------------------------------------------------------------------
    // Charger status, registered from the charger conditions
    // ------------------------------------------------------------------
    irq_status_pkg::charger_state_s chg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= irq_status_pkg::charger_status_reset;
        end else begin
            // Field order places bits 7 down to 0.
            chg_q <= charger;
        end
    end

    // ------------------------------------------------------------------
    // Read data and APB answer
    // ------------------------------------------------------------------
    logic [7:0] irq_word;

    always_comb begin
        irq_word = 8'h00;
        irq_word[irq_status_pkg::reserved_rw_bit] = reserved_rw;
        irq_word[irq_status_pkg::button_mask_bit] = mask[2];
        irq_word[irq_status_pkg::mains_mask_bit] = mask[1];
        irq_word[irq_status_pkg::bus_power_mask_bit] = mask[0];
        irq_word[irq_status_pkg::reserved_ro_bit] = 1'b0;
        irq_word[2:0] = flag;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            if (!pwrite && hit_irq) begin
                prdata <= {24'h00_0000, irq_word};
            end else if (!pwrite && hit_chg) begin
                prdata <= {24'h00_0000, chg_q};
            end else if (!pwrite && hit_lvl) begin
                prdata <= {29'h0000_0000, level_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : irq_and_charger_status_regs

/* common/irq_status_pkg.sv */
package irq_status_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] irq_flag_mask_index = 8'h02;
    localparam logic [7:0] charger_status_index = 8'h03;
    localparam logic [7:0] source_level_index = 8'h08;
    localparam logic [7:0] addr_irq_flag_mask = 8'h08;
    localparam logic [7:0] addr_charger_status = 8'h0C;
    localparam logic [7:0] addr_source_level = 8'h20;

    // ------------------------------------------------------------------
    // Interrupt register fields and reset values
    // ------------------------------------------------------------------
    localparam int reserved_rw_bit = 7;
    localparam int button_mask_bit = 6;
    localparam int mains_mask_bit = 5;
    localparam int bus_power_mask_bit = 4;
    localparam int reserved_ro_bit = 3;
    localparam int button_flag_bit = 2;
    localparam int mains_flag_bit = 1;
    localparam int bus_power_flag_bit = 0;
    localparam logic reserved_rw_reset = 1'h1;
    localparam logic [2:0] mask_reset = 3'h0;
    localparam logic [2:0] flag_reset = 3'h0;
    localparam logic [7:0] charger_status_reset = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic thermal_regulation_active;
        logic dynamic_path_loop_active;
        logic temperature_suspend;
        logic termination_detected;
        logic charging_active;
        logic charge_timer_expired;
        logic precharge_timer_expired;
        logic battery_temp_error;
    } charger_state_s;

    typedef struct packed {
        logic push_button_input;
        logic mains_present;
        logic bus_power_present;
    } source_level_s;

endpackage : irq_status_pkg

/* dv/irq_regs_sva.sv */
`timescale 1ns/1ps
module irq_regs_sva (
    input wire logic pclk, presetn, psel, penable, pwrite, // Bus controls
    input wire logic pready, pslverr, irq, // Block outputs
    input wire logic [7:0] paddr, // Byte address
    input wire logic [31:0] pwdata, prdata, // Data
    input wire logic [3:0] pstrb, // Strobes
    input wire irq_status_pkg::source_level_s sources, // Source levels
    input wire irq_status_pkg::charger_state_s charger // Charger state
);
    logic [2:0] src_q;
    logic chg_q, acc_q, rd_ok;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign rd_ok = pready && !pwrite;
    // Remembers source edges and completed accesses, the only irq causes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= '0;
            chg_q <= 1'b0;
            acc_q <= 1'b0;
        end else begin
            src_q <= sources;
            chg_q <= (sources != src_q);
            acc_q <= psel && penable && pready;
        end
    end
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not one pulse after setup");
    a_err_data: assert property (pslverr |-> pready && (pwrite || !prdata))
        else $error("error reply without ready or with data");
    a_upper_zero: assert property (rd_ok |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_bit3_zero: assert property (
        rd_ok && paddr == irq_status_pkg::addr_irq_flag_mask |-> !prdata[3])
        else $error("reserved bit 3 reads one");
    a_status_read: assert property (
        rd_ok && paddr == irq_status_pkg::addr_charger_status
        |-> prdata[7:0] == $past(charger, 2))
        else $error("charger status differs from inputs");
    a_level_read: assert property (
        rd_ok && paddr == irq_status_pkg::addr_source_level
        |-> prdata[2:0] == $past(sources, 2))
        else $error("source level differs from inputs");
    a_irq_rise: assert property (
        $rose(irq) |-> chg_q || $past(chg_q) || acc_q || $past(acc_q))
        else $error("irq rose without a cause");
    a_irq_fall: assert property ($fell(irq) |-> acc_q || $past(acc_q))
        else $error("irq fell without an access");
    cover property (irq ##1 !irq);
    cover property (pslverr);
    cover property (rd_ok && paddr == irq_status_pkg::addr_charger_status);
endmodule : irq_regs_sva
bind irq_and_charger_status_regs irq_regs_sva irq_regs_sva_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .irq(irq), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .sources(sources),
    .charger(charger));

/* dv/irq_and_charger_status_regs_tb_top.sv */
`timescale 1ns/1ps
module irq_and_charger_status_regs_tb_top;
    localparam logic [7:0] irq_a = irq_status_pkg::addr_irq_flag_mask;
    localparam logic [7:0] stat_a = irq_status_pkg::addr_charger_status;
    localparam logic [7:0] lvl_a = irq_status_pkg::addr_source_level;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, irq, err_val;
    logic [7:0] paddr = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pwdata = '0, prdata, rd_val;
    irq_status_pkg::source_level_s sources = '0;
    irq_status_pkg::charger_state_s charger = '0;
    int failures = 0, checks = 0;
    irq_and_charger_status_regs irq_and_charger_status_regs_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sources(sources),
        .charger(charger), .irq(irq));
    initial forever #2.5 pclk = ~pclk;
    task chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One bus transfer, started just after an edge, one idle cycle after.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_val = prdata;
        err_val = pslverr;
        if (n >= 50) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, rd_val, exp);
    endtask : rd
    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("irq reset", irq_a, 32'h80);
        rd("status reset", stat_a, 32'h0);
        rd("unmapped", 8'h04, 32'h0);
        chk("slverr", {31'h0, err_val}, 32'h1);
        xfer(1'b1, irq_a, 32'hFF);
        rd("irq rw", irq_a, 32'hF0);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, irq_a, 32'h80);
            sources[i] <= ~sources[i];
            repeat (3) @(posedge pclk);
            chk("irq up", {31'h0, irq}, 32'h1);
            rd("flag", irq_a, 32'h80 | (32'h1 << i));
            rd("flag clear", irq_a, 32'h80);
            chk("irq down", {31'h0, irq}, 32'h0);
            rd("level", lvl_a, {29'h0, sources});
            xfer(1'b1, irq_a, 32'h80 | (32'h10 << i));
            sources[i] <= ~sources[i];
            repeat (3) @(posedge pclk);
            chk("irq masked", {31'h0, irq}, 32'h0);
            rd("masked", irq_a, 32'h80 | (32'h11 << i));
            rd("masked clear", irq_a, 32'h80 | (32'h10 << i));
        end
        for (int i = 0; i < 8; i++) begin
            charger <= 8'h1 << i;
            repeat (2) @(posedge pclk);
            rd("status", stat_a, 32'h1 << i);
        end
        results();
    end
endmodule : irq_and_charger_status_regs_tb_top
